// >>> hdl/low_voltage_detect_reset.sv
// supply supervisor: power-on comparator reset and configurable low-voltage detector
// assumes comparator outputs are asynchronous levels, high while supply is low,
// and clk_i is the always-on supervisor clock that keeps running in stop mode
`timescale 1ns/100ps

// Contract
// - reset held while power-on comparator reports low
// - control register at FF78H, reset 00H, bit/byte
// - enable bit powers comparator, enables detection
// - mode bit: 0 interrupt, 1 reset
// - read-only flag: low supply while enabled
// - only detector reset keeps enable and mode
// - enabled interrupt mode drives flag to irq
// - low supply irq is non-maskable
// - enable and mode set give reset when low
// - irq may fire in reset mode too
// - setting mode while supply good: no reset
// - detector reset sets reset-cause bit 0
// - detector keeps working in stop mode
// - reset-cause register clears on reset, poc, read
module low_voltage_detect_reset (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic other_reset_i,
	input wire logic stop_mode_i,
	input wire logic power_on_low_i,
	input wire logic detector_low_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic bus_bit_wr_i,
	input wire logic [2:0] bus_bit_sel_i,
	input wire logic bus_bit_val_i,
	input wire logic bus_rd_i,
	output logic [7:0] bus_rdata_o,
	output logic comparator_enable_o,
	output logic low_supply_irq_o,
	output logic internal_reset_o
);
	logic [1:0] comp_sync;
	logic power_on_low_s;
	logic detector_low_s;
	logic detector_enable_r;
	logic detector_enable_nxt;
	logic detector_mode_select_r;
	logic detector_mode_select_nxt;
	logic low_supply_flag_r;
	logic [7:0] reset_cause_flags;
	logic [7:0] control_view;
	logic [7:0] rdata_nxt;
	logic bus_active;
	logic hit_control;
	logic hit_cause;
	logic byte_wr_control;
	logic bit_wr_control;
	logic detector_reset;
	logic clear_config;
	logic cause_clear;

	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
		addr_hit = (addr == target);
	endfunction

	sync_2ff #(
		.WIDTH(2)
	) u_comp_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.async_i({power_on_low_i, detector_low_i}),
		.sync_o(comp_sync)
	);

	assign power_on_low_s = comp_sync[1];
	assign detector_low_s = comp_sync[0];

	// cpu is halted in stop mode; the detector path below ignores stop_mode_i
	assign bus_active = ~stop_mode_i;
	assign hit_control = addr_hit(bus_addr_i, lvd_pkg::LOW_VOLTAGE_CONTROL_ADDR);
	assign hit_cause = addr_hit(bus_addr_i, lvd_pkg::RESET_CAUSE_FLAGS_ADDR);
	assign byte_wr_control = bus_active & bus_wr_i & hit_control;
	assign bit_wr_control = bus_active & bus_bit_wr_i & hit_control;

	// reset response only while the synchronised comparator shows low supply
	assign detector_reset = detector_enable_r & detector_mode_select_r & detector_low_s;

	// power-on and other resets clear configuration; detector reset does not
	assign clear_config = power_on_low_s | other_reset_i;
	assign cause_clear = power_on_low_s | (bus_active & bus_rd_i & hit_cause);

	always_comb begin
		detector_enable_nxt = detector_enable_r;
		detector_mode_select_nxt = detector_mode_select_r;
		if (clear_config) begin
			detector_enable_nxt = 1'b0;
			detector_mode_select_nxt = 1'b0;
		end else if (byte_wr_control) begin
			detector_enable_nxt = bus_wdata_i[lvd_pkg::DETECTOR_ENABLE_BIT];
			detector_mode_select_nxt = bus_wdata_i[lvd_pkg::DETECTOR_MODE_SELECT_BIT];
		end else if (bit_wr_control) begin
			if (bus_bit_sel_i == 3'(lvd_pkg::DETECTOR_ENABLE_BIT)) begin
				detector_enable_nxt = bus_bit_val_i;
			end
			if (bus_bit_sel_i == 3'(lvd_pkg::DETECTOR_MODE_SELECT_BIT)) begin
				detector_mode_select_nxt = bus_bit_val_i;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			detector_enable_r <= lvd_pkg::LOW_VOLTAGE_CONTROL_RST[lvd_pkg::DETECTOR_ENABLE_BIT];
			detector_mode_select_r <=
				lvd_pkg::LOW_VOLTAGE_CONTROL_RST[lvd_pkg::DETECTOR_MODE_SELECT_BIT];
		end else if (clk_en_i) begin
			detector_enable_r <= detector_enable_nxt;
			detector_mode_select_r <= detector_mode_select_nxt;
		end
	end

	reset_cause_reg u_cause (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.set_i(detector_reset),
		.clear_i(cause_clear),
		.flags_o(reset_cause_flags)
	);

	always_comb begin
		control_view = lvd_pkg::LOW_VOLTAGE_CONTROL_RST;
		control_view[lvd_pkg::DETECTOR_ENABLE_BIT] = detector_enable_r;
		control_view[lvd_pkg::DETECTOR_MODE_SELECT_BIT] = detector_mode_select_r;
		control_view[lvd_pkg::LOW_SUPPLY_FLAG_BIT] = low_supply_flag_r;
	end

	assign rdata_nxt = hit_control ? control_view :
		hit_cause ? reset_cause_flags : lvd_pkg::UNMAPPED_READ;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			low_supply_flag_r <= 1'b0;
			comparator_enable_o <= 1'b0;
			low_supply_irq_o <= 1'b0;
			internal_reset_o <= 1'b0;
			bus_rdata_o <= lvd_pkg::UNMAPPED_READ;
		end else if (clk_en_i) begin
			low_supply_flag_r <= detector_enable_r & detector_low_s;
			comparator_enable_o <= detector_enable_r;
			// no mask term; fires in either mode since the flag is mode-blind
			low_supply_irq_o <= detector_enable_r & detector_low_s;
			internal_reset_o <= power_on_low_s | detector_reset;
			if (bus_active & bus_rd_i) begin
				bus_rdata_o <= rdata_nxt;
			end
		end
	end
endmodule

// >>> inc/lvd_pkg.sv
// constants for the supply supervisor: register addresses, field positions, reset values
// assumes an 8-bit internal bus with 16-bit addresses and bit or byte writes
package lvd_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int BIT_SEL_W = 3;

	// register addresses
	localparam logic [15:0] LOW_VOLTAGE_CONTROL_ADDR = 16'hFF78;
	localparam logic [15:0] RESET_CAUSE_FLAGS_ADDR = 16'hFFAC;

	// low_voltage_control fields
	localparam int DETECTOR_ENABLE_BIT = 7;
	localparam int DETECTOR_MODE_SELECT_BIT = 1;
	localparam int LOW_SUPPLY_FLAG_BIT = 0;
	localparam logic [7:0] LOW_VOLTAGE_CONTROL_RST = 8'h00;

	// reset_cause_flags fields
	localparam int DETECTOR_RESET_CAUSE_BIT = 0;
	localparam logic [7:0] RESET_CAUSE_FLAGS_RST = 8'h00;

	// value on the read port for an unmapped address
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// >>> hdl/sync_2ff.sv
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/100ps
module sync_2ff #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	// the first stage feeds only the second stage
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else if (clk_en_i) begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// >>> hdl/reset_cause_reg.sv
// reset-cause flag register with read-to-clear
// assumes clear_i marks a read of the register or a power-on comparator reset
`timescale 1ns/100ps
module reset_cause_reg (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic set_i,
	input wire logic clear_i,
	output logic [7:0] flags_o
);
	logic detector_reset_cause_r;
	logic detector_reset_cause_nxt;

	// set wins so a cause arriving during a read is not lost
	assign detector_reset_cause_nxt = set_i | (detector_reset_cause_r & ~clear_i);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			detector_reset_cause_r <= lvd_pkg::RESET_CAUSE_FLAGS_RST[lvd_pkg::DETECTOR_RESET_CAUSE_BIT];
		end else if (clk_en_i) begin
			detector_reset_cause_r <= detector_reset_cause_nxt;
		end
	end

	always_comb begin
		flags_o = lvd_pkg::RESET_CAUSE_FLAGS_RST;
		flags_o[lvd_pkg::DETECTOR_RESET_CAUSE_BIT] = detector_reset_cause_r;
	end
endmodule

// >>> tb/supply_model.sv
// analog comparator stand-in: levels commanded by the bench
// assumes commands change at the falling edge; outputs move off-edge, like a real comparator
`timescale 1ns/100ps
module supply_model (
	input wire logic poc_cmd_i,
	input wire logic det_cmd_i,
	output logic power_on_low_o,
	output logic detector_low_o
);
	// skewed delays keep both levels asynchronous to the sampling edge
	assign #1.3 power_on_low_o = poc_cmd_i;
	assign #0.7 detector_low_o = det_cmd_i;
endmodule

// >>> tb/low_voltage_detect_reset_chk.sv
// concurrent checks on the supervisor's ports
// assumes clk_en_i is held high, so the comparator path is three edges long
`timescale 1ns/100ps
module low_voltage_detect_reset_chk (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic stop_mode_i,
	input wire logic power_on_low_i,
	input wire logic detector_low_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic bus_rd_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic comparator_enable_o,
	input wire logic low_supply_irq_o,
	input wire logic internal_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// history older than three edges may predate reset release
	logic [1:0] up_r;
	wire settled = up_r == 2'h3;
	wire mapped = bus_addr_i == lvd_pkg::LOW_VOLTAGE_CONTROL_ADDR
		|| bus_addr_i == lvd_pkg::RESET_CAUSE_FLAGS_ADDR;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) up_r <= 2'h0;
		else if (!settled) up_r <= up_r + 2'h1;
	end
	sequence rd_ctrl;
		bus_rd_i && !stop_mode_i && bus_addr_i == lvd_pkg::LOW_VOLTAGE_CONTROL_ADDR;
	endsequence
	chk_por_reset: assert property (
		settled && $past(power_on_low_i, 3) |-> internal_reset_o)
		else $error("power-on low without internal reset");
	chk_irq_follows: assert property (settled |->
		low_supply_irq_o == (comparator_enable_o && $past(detector_low_i, 3)))
		else $error("irq does not follow enabled detector");
	chk_quiet_supply: assert property (settled && !$past(power_on_low_i, 3)
		&& !$past(detector_low_i, 3) |-> !internal_reset_o)
		else $error("internal reset with good supply");
	chk_enable_read: assert property (
		rd_ctrl |=> bus_rdata_o[7] == comparator_enable_o)
		else $error("enable bit read differs from comparator enable");
	// flag is rebuilt from the comparator input, not from the irq it shares logic with
	chk_flag_read: assert property (
		bus_rd_i && !stop_mode_i && settled && bus_addr_i == lvd_pkg::LOW_VOLTAGE_CONTROL_ADDR
		|=> bus_rdata_o[0] == ($past(comparator_enable_o) && $past(detector_low_i, 4)))
		else $error("flag read differs from detector state");
	chk_reserved_zero: assert property (
		rd_ctrl |=> bus_rdata_o[6:2] == 5'h00)
		else $error("reserved control bits read nonzero");
	chk_unmapped_read: assert property (bus_rd_i && !stop_mode_i && !mapped
		|=> bus_rdata_o == lvd_pkg::UNMAPPED_READ)
		else $error("unmapped read returned data");
	chk_stop_noread: assert property (
		stop_mode_i && bus_rd_i |=> $stable(bus_rdata_o))
		else $error("read taken in stop mode");
endmodule
bind low_voltage_detect_reset low_voltage_detect_reset_chk chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .stop_mode_i(stop_mode_i), .power_on_low_i(power_on_low_i),
	.detector_low_i(detector_low_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
	.bus_rdata_o(bus_rdata_o), .comparator_enable_o(comparator_enable_o),
	.low_supply_irq_o(low_supply_irq_o), .internal_reset_o(internal_reset_o));

// >>> tb/test_low_voltage_detect_reset.sv
// register-level tests of the supply supervisor acting as cpu software
// assumes inputs change at falling edges and clk_en_i stays high
`timescale 1ns/100ps
module test_low_voltage_detect_reset;
	localparam logic [15:0] CTL = lvd_pkg::LOW_VOLTAGE_CONTROL_ADDR;
	localparam logic [15:0] CAU = lvd_pkg::RESET_CAUSE_FLAGS_ADDR;
	// 0.2 ms comparator settling in 5 ns cycles
	localparam int SETTLE_CYC = 40000;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, oth = 1'b0, stop = 1'b0, power_on_comparator = 1'b0, det = 1'b0;
	logic wr = 1'b0, bw = 1'b0, rd = 1'b0, bval = 1'b0, pl, dl, ce, irq, irst;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00, rdat;
	logic [2:0] bsel = 3'h0;
	int err_total = 0, comparisons = 0;
	always #2.5 clk_i = ~clk_i;
	supply_model sup (.poc_cmd_i(power_on_comparator), .det_cmd_i(det), .power_on_low_o(pl), .detector_low_o(dl));
	low_voltage_detect_reset dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
		.other_reset_i(oth), .stop_mode_i(stop), .power_on_low_i(pl), .detector_low_i(dl),
		.bus_addr_i(addr), .bus_wr_i(wr), .bus_wdata_i(wd), .bus_bit_wr_i(bw),
		.bus_bit_sel_i(bsel), .bus_bit_val_i(bval), .bus_rd_i(rd), .bus_rdata_o(rdat),
		.comparator_enable_o(ce), .low_supply_irq_o(irq), .internal_reset_o(irst));
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk_i);
	endtask
	// each access ends with an idle cycle so back-to-back calls never re-raise a strobe at once
	task automatic wbyte(logic [15:0] a, logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic wbit(logic [2:0] s, logic v);
		addr = CTL;
		bsel = s;
		bval = v;
		bw = 1'b1;
		cyc(1);
		bw = 1'b0;
		cyc(1);
	endtask
	task automatic rchk(string what, logic [15:0] a, logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		check(what, rdat, exp);
		cyc(1);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		// one settle wait plus 2000 cycles, far above the hundred or so cycles of register traffic
		repeat (SETTLE_CYC + 2000) @(posedge clk_i);
		err_total++;
		summarize();
	end
	initial begin
		cyc(4);
		sys_rst_i = 1'b0;
		// model supply is steady, so one cycle covers the fluctuation wait
		cyc(1);
		rchk("ctl reset", CTL, 8'h00);
		rchk("cause reset", CAU, 8'h00);
		wbit(3'h7, 1'b1);
		check("comp en", {7'h0, ce}, 8'h01);
		// interrupt use: supply confirmed good before any interrupt is relied on
		rchk("flag good irq", CTL, 8'h80);
		wbyte(CTL, 8'hFF);
		wbyte(CAU, 8'hFF);
		rchk("ctl ro bits", CTL, 8'h82);
		rchk("cause ro", CAU, 8'h00);
		rchk("unmapped", 16'h1234, lvd_pkg::UNMAPPED_READ);
		wbit(3'h1, 1'b0);
		$display("test registers done");
		det = 1'b1;
		cyc(5);
		check("irq", {7'h0, irq}, 8'h01);
		check("no rst irq mode", {7'h0, irst}, 8'h00);
		rchk("flag low", CTL, 8'h81);
		wbyte(CTL, 8'h00);
		cyc(5);
		check("irq disabled", {7'h0, irq}, 8'h00);
		check("comp off", {7'h0, ce}, 8'h00);
		rchk("flag disabled", CTL, 8'h00);
		det = 1'b0;
		$display("test interrupt done");
		wbit(3'h7, 1'b1);
		cyc(SETTLE_CYC);
		rchk("flag good", CTL, 8'h80);
		wbit(3'h1, 1'b1);
		cyc(5);
		check("mode set good", {7'h0, irst}, 8'h00);
		stop = 1'b1;
		det = 1'b1;
		cyc(5);
		check("det reset", {7'h0, irst}, 8'h01);
		check("irq rst mode", {7'h0, irq}, 8'h01);
		rchk("stop read held", CTL, 8'h80);
		wbit(3'h1, 1'b0);
		stop = 1'b0;
		det = 1'b0;
		cyc(5);
		rchk("kept by det", CTL, 8'h82);
		rchk("cause set", CAU, 8'h01);
		rchk("cause rd clr", CAU, 8'h00);
		oth = 1'b1;
		cyc(1);
		oth = 1'b0;
		rchk("other clr", CTL, 8'h00);
		$display("test reset mode done");
		wbyte(CTL, 8'h82);
		det = 1'b1;
		cyc(5);
		det = 1'b0;
		cyc(5);
		power_on_comparator = 1'b1;
		cyc(5);
		check("poc reset", {7'h0, irst}, 8'h01);
		power_on_comparator = 1'b0;
		cyc(5);
		rchk("poc clr", CTL, 8'h00);
		rchk("poc cause clr", CAU, 8'h00);
		$display("test power on done");
		summarize();
	end
endmodule
